// >>> hw/pma_pkg.sv
// Shared constants and types for the program memory address map
package pma_pkg;

    // Program counter and fixed vectors
    localparam int PC_W = 21;
    localparam logic [20:0] RESET_VECTOR = 21'h000000;
    localparam logic [20:0] HIGH_VECTOR = 21'h000008;
    localparam logic [20:0] LOW_VECTOR = 21'h000018;
    localparam logic [20:0] PC_STEP = 21'h000002;

    // On-chip flash sizes of the three variants, and boot block sizes
    localparam logic [20:0] FLASH_32K_BYTES = 21'h008000;
    localparam logic [20:0] FLASH_64K_BYTES = 21'h010000;
    localparam logic [20:0] FLASH_128K_BYTES = 21'h020000;
    localparam logic [20:0] BOOT_2K_BYTES = 21'h000800;
    localparam logic [20:0] BOOT_512_BYTES = 21'h000200;

    // Memory mode select codes
    localparam logic [1:0] ONCHIP_ONLY_MODE = 2'h3;
    localparam logic [1:0] EXTERNAL_ONLY_MODE = 2'h2;
    localparam logic [1:0] BOOT_BLOCK_PLUS_EXTERNAL_MODE = 2'h1;
    localparam logic [1:0] ONCHIP_PLUS_EXTERNAL_MODE = 2'h0;
    localparam logic [1:0] MODE_RESET = 2'h3;

    // Return stack
    localparam int STACK_DEPTH = 31;
    localparam logic [4:0] SP_RESET = 5'h00;
    localparam logic [4:0] SP_FULL = 5'h1f;
    localparam logic [4:0] SP_ONE = 5'h01;

    typedef enum logic [1:0] {REGION_ONCHIP, REGION_EXTERNAL, REGION_ZERO} pma_region_t;

endpackage

// >>> hw/pma_region_decode.sv
// Address to memory region decoder for one program bus address
`timescale 1ns/1ps
module pma_region_decode #(
    parameter logic [20:0] FLASH_BYTES = pma_pkg::FLASH_128K_BYTES,
    parameter logic [20:0] BOOT_BYTES = pma_pkg::BOOT_512_BYTES,
    parameter bit HAS_EXT_BUS = 1'b1
)
(
    input wire logic [20:0] addr,
    input wire logic [1:0] mode,
    output pma_pkg::pma_region_t region
);

    // Parts without the external bus only know the on-chip mode
    wire logic [1:0] eff_mode = HAS_EXT_BUS ? mode : pma_pkg::ONCHIP_ONLY_MODE;
    wire logic below_flash = addr < FLASH_BYTES;
    wire logic below_boot = addr < BOOT_BYTES;
    // RULE2 - zero fill above flash
    wire pma_pkg::pma_region_t onchip_region =
        below_flash ? pma_pkg::REGION_ONCHIP : pma_pkg::REGION_ZERO;
    // RULE13 - automatic boundary switch
    wire pma_pkg::pma_region_t boot_region =
        below_boot ? pma_pkg::REGION_ONCHIP : pma_pkg::REGION_EXTERNAL;
    wire pma_pkg::pma_region_t extended_region =
        below_flash ? pma_pkg::REGION_ONCHIP : pma_pkg::REGION_EXTERNAL;

    // RULE12 - mode code decode
    assign region =
        (eff_mode == pma_pkg::ONCHIP_ONLY_MODE) ? onchip_region :
        (eff_mode == pma_pkg::EXTERNAL_ONLY_MODE) ? pma_pkg::REGION_EXTERNAL :
        (eff_mode == pma_pkg::BOOT_BLOCK_PLUS_EXTERNAL_MODE) ? boot_region :
        extended_region;

endmodule // pma_region_decode

// >>> hw/pma_program_map.sv
// Program counter, program bus routing and interrupt wake-up vectoring
// Overview of operation
// RULE1 - Program counter is 21 bits wide, covering a 2-Mbyte linear program space.
// RULE2 - Reads above implemented program memory return all zeros, a no-operation.
// RULE3 - Smallest variant has 32 Kbytes of flash, 16,384 instruction words.
// RULE4 - Middle variant has 64 Kbytes of flash, 32,768 instruction words.
// RULE5 - Largest variant has 128 Kbytes of flash, 65,536 instruction words.
// RULE6 - After any reset, fetching starts at address zero.
// RULE7 - Interrupt vectors sit at 0008h and 0018h.
// RULE8 - Program bus is separate from data memory, so both run together.
// RULE9 - With external bus, mode routes fetches internal, external or split.
// RULE10 - Interrupt wake-up with a global enable set loads the matching vector.
// RULE11 - That wake-up pushes the PC to stack top and advances the pointer; with the pointer at 1fh the code loads the vector but skips the push.
// RULE12 - Mode field: 11 on-chip, 10 external, 01 boot plus external, 00 both.
// RULE13 - Combined modes switch memories automatically at the on-chip boundary.
// RULE14 - Flash size is a parameter so one decoder serves every variant.
`timescale 1ns/1ps
module pma_program_map #(
    parameter logic [20:0] FLASH_BYTES = pma_pkg::FLASH_128K_BYTES,
    parameter logic [20:0] BOOT_BYTES = pma_pkg::BOOT_512_BYTES,
    parameter bit HAS_EXT_BUS = 1'b1
)
(
    input wire logic MCLK,
    input wire logic RST,
    input wire logic [1:0] MEMORY_MODE_SELECT,
    input wire logic FETCH_REQ,
    output logic FETCH_READY,
    output logic [20:0] PC,
    output logic [15:0] INSTR_DATA,
    output logic INSTR_VALID,
    input wire logic PC_LOAD,
    input wire logic [20:0] PC_LOAD_VALUE,
    input wire logic TBL_REQ,
    input wire logic [20:0] TBL_ADDR,
    output logic [7:0] TBL_DATA,
    output logic TBL_VALID,
    input wire logic WAKE_INT,
    input wire logic INT_HIGH_PRIORITY,
    input wire logic HIGH_PRIORITY_GLOBAL_INT_ENABLE,
    input wire logic LOW_PRIORITY_GLOBAL_INT_ENABLE,
    input wire logic STACK_POP,
    output logic [7:0] STACK_TOP_UPPER,
    output logic [7:0] STACK_TOP_HIGH,
    output logic [7:0] STACK_TOP_LOW,
    output logic [4:0] RETURN_STACK_POINTER,
    output logic [19:0] FLASH_ADDR,
    output logic FLASH_RD,
    input wire logic [15:0] FLASH_RDATA,
    output logic [20:0] EXT_ADDR,
    output logic EXT_RD,
    input wire logic [15:0] EXT_RDATA
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [20:0] pc;
    logic [4:0] sp;
    logic [20:0] stack_top;
    localparam int STACK_DEPTH_L = pma_pkg::STACK_DEPTH;
    logic [20:0] stack_mem [1:STACK_DEPTH_L];
    logic [1:0] mode_meta;
    logic [1:0] mode_sync;
    logic [1:0] mode_cfg;
    logic mode_taken;
    pma_pkg::pma_region_t rd_region;
    logic rd_fetch;
    logic rd_tbl;
    logic rd_odd;

    ////////////////////////////////////////////////////////////////////////////
    // Request decode

    wire logic wake_take = WAKE_INT
        && (HIGH_PRIORITY_GLOBAL_INT_ENABLE || LOW_PRIORITY_GLOBAL_INT_ENABLE);
    // RULE7 - vector choice
    wire logic [20:0] int_vector = INT_HIGH_PRIORITY ? pma_pkg::HIGH_VECTOR
        : pma_pkg::LOW_VECTOR;
    wire logic push_ok = wake_take && (sp != pma_pkg::SP_FULL);
    wire logic pop_ok = STACK_POP && !wake_take && (sp != pma_pkg::SP_RESET);
    wire logic [4:0] sp_up = sp + pma_pkg::SP_ONE;
    wire logic [4:0] sp_down = sp - pma_pkg::SP_ONE;
    wire logic [20:0] below_top = (sp_down == pma_pkg::SP_RESET) ? 21'h000000
        : stack_mem[sp_down];
    // Table reads own the program bus for their cycle; anything that moves
    // the PC also blocks the sequential fetch so it never sees a stale PC.
    assign FETCH_READY = !TBL_REQ && !wake_take && !PC_LOAD && !STACK_POP;
    wire logic fetch_go = FETCH_REQ && FETCH_READY;
    wire logic bus_go = fetch_go || TBL_REQ;
    wire logic [20:0] bus_addr = TBL_REQ ? TBL_ADDR : pc;
    pma_pkg::pma_region_t bus_region;
    // RULE1 - sequential advance
    wire logic [20:0] next_pc = wake_take ? int_vector
        : pop_ok ? stack_top
        : PC_LOAD ? PC_LOAD_VALUE
        : fetch_go ? pc + pma_pkg::PC_STEP
        : pc;

    // RULE14 - shared decoder
    pma_region_decode #(
        .FLASH_BYTES(FLASH_BYTES),
        .BOOT_BYTES(BOOT_BYTES),
        .HAS_EXT_BUS(HAS_EXT_BUS)
    ) u_decode (
        .addr(bus_addr),
        .mode(mode_cfg),
        .region(bus_region)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Program bus (kept apart from any data memory port)

    // RULE8 - dedicated program bus
    assign FLASH_RD = bus_go && (bus_region == pma_pkg::REGION_ONCHIP);
    // RULE9 - mode routing
    assign EXT_RD = bus_go && (bus_region == pma_pkg::REGION_EXTERNAL);
    assign FLASH_ADDR = bus_addr[20:1];
    assign EXT_ADDR = bus_addr;
    // RULE2 - zero word
    wire logic [15:0] rd_word = (rd_region == pma_pkg::REGION_ONCHIP) ? FLASH_RDATA
        : (rd_region == pma_pkg::REGION_EXTERNAL) ? EXT_RDATA
        : 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // Memory mode strap: synchronised, then frozen once after reset

    always_ff @(posedge MCLK)
    begin
        mode_meta <= MEMORY_MODE_SELECT;
        mode_sync <= mode_meta;
        if (RST)
        begin
            mode_cfg <= pma_pkg::MODE_RESET;
            mode_taken <= 1'b0;
        end
        else if (!mode_taken)
        begin
            mode_cfg <= mode_sync;
            mode_taken <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Program counter and read pipeline

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            // RULE6 - reset vector
            pc <= pma_pkg::RESET_VECTOR;
            rd_region <= pma_pkg::REGION_ZERO;
            rd_fetch <= 1'b0;
            rd_tbl <= 1'b0;
            rd_odd <= 1'b0;
            INSTR_DATA <= 16'h0000;
            INSTR_VALID <= 1'b0;
            TBL_DATA <= 8'h00;
            TBL_VALID <= 1'b0;
        end
        else
        begin
            // RULE10 - wake vector load
            pc <= next_pc;
            rd_region <= bus_region;
            rd_fetch <= fetch_go;
            rd_tbl <= TBL_REQ;
            rd_odd <= bus_addr[0];
            INSTR_VALID <= rd_fetch;
            TBL_VALID <= rd_tbl;
            if (rd_fetch)
            begin
                INSTR_DATA <= rd_word;
            end
            if (rd_tbl)
            begin
                TBL_DATA <= rd_odd ? rd_word[15:8] : rd_word[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Return stack; a full stack drops further pushes

    always_ff @(posedge MCLK)
    begin
        if (RST)
        begin
            sp <= pma_pkg::SP_RESET;
            stack_top <= 21'h000000;
        end
        else if (push_ok)
        begin
            // RULE11 - push on wake
            sp <= sp_up;
            stack_top <= pc;
        end
        else if (pop_ok)
        begin
            sp <= sp_down;
            stack_top <= below_top;
        end
    end

    always_ff @(posedge MCLK)
    begin
        if (push_ok)
        begin
            stack_mem[sp_up] <= pc;
        end
    end

    assign PC = pc;
    assign RETURN_STACK_POINTER = sp;
    assign STACK_TOP_UPPER = {3'h0, stack_top[20:16]};
    assign STACK_TOP_HIGH = stack_top[15:8];
    assign STACK_TOP_LOW = stack_top[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    // RULE6 - start address
    reset_vector_a: assert property ($past(RST) |-> pc == 21'h000000) // RULE6
        else $error("PC not at reset vector after reset");
    // RULE1 - fetch increment
    pc_step_a: assert property (fetch_go |=> pc == $past(pc) + 21'h000002) // RULE1
        else $error("PC did not step by one word");
    // RULE2 - zero fill
    zero_fill_a: assert property (fetch_go && bus_region == pma_pkg::REGION_ZERO // RULE2
        |=> ##1 INSTR_VALID && INSTR_DATA == 16'h0000)
        else $error("Out of range fetch did not read zero");
    // RULE4 - middle size
    // RULE5 - largest size
    flash_size_a: assert property (bus_go && (mode_cfg == 2'h3 || !HAS_EXT_BUS) // RULE3
        |-> FLASH_RD == (bus_addr < FLASH_BYTES) && (FLASH_BYTES == 21'h008000
        || FLASH_BYTES == 21'h010000 || FLASH_BYTES == 21'h020000))
        else $error("On-chip read does not match a known flash size");
    // RULE14 - decoder bound
    onchip_bound_a: assert property (FLASH_RD |-> bus_addr < FLASH_BYTES) // RULE14
        else $error("On-chip read above flash size");
    // RULE7 - vector values
    int_vector_a: assert property (wake_take |=> pc == // RULE10
        ($past(INT_HIGH_PRIORITY) ? 21'h000008 : 21'h000018))
        else $error("Wake-up did not load the interrupt vector");
    // RULE11 - stack push
    stack_push_a: assert property (push_ok |=> sp == $past(sp) + 5'h01 // RULE11
        && stack_top == $past(pc))
        else $error("Wake-up did not push the PC");
    one_memory_a: assert property (!(FLASH_RD && EXT_RD)) // RULE8
        else $error("Program bus drove both memories");
    onchip_mode_a: assert property (mode_cfg == 2'h3 |-> !EXT_RD) // RULE9
        else $error("External read in on-chip only mode");
    ext_only_a: assert property (bus_go && mode_cfg == 2'h2 && HAS_EXT_BUS // RULE12
        |-> EXT_RD && !FLASH_RD)
        else $error("External only mode read on-chip flash");
    boot_switch_a: assert property (bus_go && mode_cfg == 2'h1 && HAS_EXT_BUS // RULE13
        |-> (bus_addr < BOOT_BYTES) == FLASH_RD)
        else $error("Boot block boundary switch wrong");

endmodule // pma_program_map

// >>> verification/pma_mem_model.sv
// Behavioural on-chip flash and external program memory
`timescale 1ns/1ps
module pma_mem_model
(
    input wire logic clk,
    input wire logic [19:0] flash_addr,
    input wire logic flash_rd,
    output logic [15:0] flash_rdata,
    input wire logic [20:0] ext_addr,
    input wire logic ext_rd,
    output logic [15:0] ext_rdata
);
    // Top nibble marks the source, so a wrong route cannot pass
    // Between reads the lines toggle, so stale data never looks valid
    initial
    begin
        flash_rdata = 16'h0000;
        ext_rdata = 16'h0000;
    end
    always @(posedge clk)
    begin
        flash_rdata <= flash_rd ? {4'h1, flash_addr[11:0]} : ~flash_rdata;
        ext_rdata <= ext_rd ? {4'h2, ext_addr[12:1]} : ~ext_rdata;
    end
endmodule // pma_mem_model

// >>> verification/pma_program_map_tb_top.sv
// Self-checking bench for the program memory address map
`timescale 1ns/1ps
module pma_program_map_tb_top;
    logic MCLK, RST, FETCH_REQ, FETCH_READY, INSTR_VALID, PC_LOAD, TBL_REQ, TBL_VALID;
    logic WAKE_INT, INT_HIGH_PRIORITY, INT_EN_HIGH, INT_EN_LOW, STACK_POP, FLASH_RD, EXT_RD;
    logic [1:0] strap;
    logic [20:0] PC, PC_LOAD_VALUE, TBL_ADDR, EXT_ADDR;
    logic [15:0] INSTR_DATA, FLASH_RDATA, EXT_RDATA;
    logic [7:0] TBL_DATA, tos_u, tos_h, tos_l;
    logic [4:0] sp;
    logic [19:0] FLASH_ADDR;
    int fail_count = 0;
    int checks = 0;
    int cycles = 0;
    pma_program_map #(.FLASH_BYTES(pma_pkg::FLASH_32K_BYTES),
        .BOOT_BYTES(pma_pkg::BOOT_2K_BYTES), .HAS_EXT_BUS(1'b1)) pma_program_map_i (
        .MCLK(MCLK), .RST(RST), .MEMORY_MODE_SELECT(strap), .FETCH_REQ(FETCH_REQ),
        .FETCH_READY(FETCH_READY), .PC(PC), .INSTR_DATA(INSTR_DATA),
        .INSTR_VALID(INSTR_VALID), .PC_LOAD(PC_LOAD), .PC_LOAD_VALUE(PC_LOAD_VALUE),
        .TBL_REQ(TBL_REQ), .TBL_ADDR(TBL_ADDR), .TBL_DATA(TBL_DATA), .TBL_VALID(TBL_VALID),
        .WAKE_INT(WAKE_INT), .INT_HIGH_PRIORITY(INT_HIGH_PRIORITY),
        .HIGH_PRIORITY_GLOBAL_INT_ENABLE(INT_EN_HIGH),
        .LOW_PRIORITY_GLOBAL_INT_ENABLE(INT_EN_LOW),
        .STACK_POP(STACK_POP), .STACK_TOP_UPPER(tos_u), .STACK_TOP_HIGH(tos_h),
        .STACK_TOP_LOW(tos_l), .RETURN_STACK_POINTER(sp), .FLASH_ADDR(FLASH_ADDR),
        .FLASH_RD(FLASH_RD), .FLASH_RDATA(FLASH_RDATA), .EXT_ADDR(EXT_ADDR),
        .EXT_RD(EXT_RD), .EXT_RDATA(EXT_RDATA));
    pma_mem_model pma_mem_model_i (.clk(MCLK), .flash_addr(FLASH_ADDR), .flash_rd(FLASH_RD),
        .flash_rdata(FLASH_RDATA), .ext_addr(EXT_ADDR), .ext_rd(EXT_RD), .ext_rdata(EXT_RDATA));
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end
    // Whole run needs under two hundred cycles; the ceiling leaves wide margin
    always @(posedge MCLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 5000)
        begin
            fail_count++;
            test_done();
        end
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [20:0] exp, input logic [20:0] got);
        checks++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask
    // Expected word from mode and byte address, worked out independently
    function automatic logic [15:0] exp_word(input logic [1:0] m, input logic [20:0] a);
        logic on_chip;
        on_chip = (m == pma_pkg::ONCHIP_ONLY_MODE || m == pma_pkg::ONCHIP_PLUS_EXTERNAL_MODE) ?
            a < pma_pkg::FLASH_32K_BYTES :
            (m == pma_pkg::BOOT_BLOCK_PLUS_EXTERNAL_MODE && a < pma_pkg::BOOT_2K_BYTES);
        if (on_chip)
            return {4'h1, a[12:1]};
        return (m == pma_pkg::ONCHIP_ONLY_MODE) ? 16'h0000 : {4'h2, a[12:1]};
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic do_reset(input logic [1:0] m);
        strap = m;
        RST = 1'b1;
        repeat (16) @(negedge MCLK);
        RST = 1'b0;
        repeat (3) @(negedge MCLK);
        chk("pc after reset", 21'h000000, PC);
        chk("pointer after reset", 21'h000000, 21'(sp));
    endtask
    task automatic load_pc(input logic [20:0] v);
        PC_LOAD = 1'b1;
        PC_LOAD_VALUE = v;
        @(negedge MCLK);
        PC_LOAD = 1'b0;
    endtask
    task automatic fetch(input logic [20:0] a);
        chk("fetch pc", a, PC);
        FETCH_REQ = 1'b1;
        // Ready is combinational; let it settle on inputs changed in this time step
        #1;
        chk("fetch ready", 21'h000001, 21'(FETCH_READY));
        @(negedge MCLK);
        FETCH_REQ = 1'b0;
        chk("pc step", a + pma_pkg::PC_STEP, PC);
        @(negedge MCLK);
        chk("instr valid", 21'h000001, 21'(INSTR_VALID));
        chk("instr data", 21'(exp_word(strap, a)), 21'(INSTR_DATA));
    endtask
    task automatic wake(input logic hi, input logic eh, input logic el, input logic [20:0] v);
        logic [20:0] old_pc;
        logic [4:0] old_sp;
        old_pc = PC;
        old_sp = sp;
        {WAKE_INT, INT_HIGH_PRIORITY, INT_EN_HIGH, INT_EN_LOW} = {1'b1, hi, eh, el};
        @(negedge MCLK);
        WAKE_INT = 1'b0;
        chk("wake pc", (eh | el) ? v : old_pc, PC);
        chk("wake pointer", 21'(old_sp + ((eh | el) ? 5'h01 : 5'h00)), 21'(sp));
        if (eh | el)
            chk("wake stack top", old_pc, {tos_u[4:0], tos_h, tos_l});
        // Idle cycle, so the next request never reuses this time step
        @(negedge MCLK);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic test_fetch();
        do_reset(pma_pkg::ONCHIP_ONLY_MODE);
        fetch(21'h000000);
        load_pc(21'h007ffe);
        fetch(21'h007ffe);
        fetch(21'h008000);
        load_pc(21'h1ffffe);
        fetch(21'h1ffffe);
        chk("pc wrap", 21'h000000, PC);
    endtask
    task automatic test_modes();
        logic [20:0] addrs [3] = '{21'h000100, 21'h000901, 21'h008000};
        logic [15:0] w;
        logic [7:0] b;
        for (int m = 0; m < 4; m++)
        begin
            do_reset(2'(m));
            foreach (addrs[i])
            begin
                TBL_REQ = 1'b1;
                TBL_ADDR = addrs[i];
                @(negedge MCLK);
                TBL_REQ = 1'b0;
                @(negedge MCLK);
                w = exp_word(2'(m), addrs[i]);
                b = addrs[i][0] ? w[15:8] : w[7:0];
                chk("table valid", 21'h000001, 21'(TBL_VALID));
                chk("table byte", 21'(b), 21'(TBL_DATA));
            end
        end
    endtask
    task automatic test_wake();
        do_reset(pma_pkg::ONCHIP_ONLY_MODE);
        load_pc(21'h001234);
        wake(1'b1, 1'b1, 1'b0, pma_pkg::HIGH_VECTOR);
        fetch(21'h000008);
        wake(1'b0, 1'b0, 1'b1, pma_pkg::LOW_VECTOR);
        wake(1'b1, 1'b0, 1'b0, pma_pkg::HIGH_VECTOR);
        STACK_POP = 1'b1;
        @(negedge MCLK);
        STACK_POP = 1'b0;
        chk("pop pc", 21'h00000a, PC);
        chk("pop stack top", 21'h001234, {tos_u[4:0], tos_h, tos_l});
    endtask
    initial
    begin
        {RST, FETCH_REQ, PC_LOAD, TBL_REQ, WAKE_INT, INT_HIGH_PRIORITY} = 6'h21;
        {INT_EN_HIGH, INT_EN_LOW, STACK_POP} = 3'h0;
        strap = pma_pkg::ONCHIP_ONLY_MODE;
        PC_LOAD_VALUE = 21'h000000;
        TBL_ADDR = 21'h000000;
        @(negedge MCLK);
        test_fetch();
        test_modes();
        test_wake();
        test_done();
    end
endmodule // pma_program_map_tb_top
